// >>> src/pafs_edge_det.sv
`timescale 1ns/10ps
// edge detection with optional two-sample filter for rising mode
module pafs_edge_det (
	input  wire logic clock,
	input  wire logic rst_n,
	pafs_irq_if.det   irq
);
	import pafs_pkg::*;

	logic [2:0] prev_reg;
	logic [2:0] samp_reg;
	logic [2:0] pair_reg;
	logic [2:0] req_reg;
	logic [2:0] fire;

	// decide per pin whether its selected edge has occurred
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			pafs_edge_e e;
			e = pafs_edge_e'(irq.edge_sel[2*i +: 2]);
			if (irq.samp_en[i] && e == EDGE_RISE) begin
				fire[i] = irq.tick && irq.level[i] && samp_reg[i] && !pair_reg[i]; // [RULE14]
			end else begin
				unique case (e) // [RULE12] [RULE19]
					EDGE_NONE: fire[i] = 1'b0;
					EDGE_RISE: fire[i] = irq.level[i] && !prev_reg[i];
					EDGE_FALL: fire[i] = !irq.level[i] && prev_reg[i];
					EDGE_BOTH: fire[i] = irq.level[i] != prev_reg[i];
				endcase
			end
		end
	end

	// level of the previous clock cycle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			prev_reg <= 3'h0;
		end else begin
			prev_reg <= irq.level; // [RULE19]
		end
	end

	// samples taken at each tick and the pair status
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			samp_reg <= 3'h0;
			pair_reg <= 3'h0;
		end else if (irq.tick) begin
			samp_reg <= irq.level; // [RULE13]
			pair_reg <= irq.level & samp_reg; // [RULE14]
		end
	end

	// one-cycle request on the clock after detection
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			req_reg <= 3'h0;
		end else begin
			req_reg <= fire & irq.int_en; // [RULE11] [RULE15]
		end
	end

	assign irq.req = req_reg;
endmodule

// >>> src/pafs_irq_if.sv
`timescale 1ns/10ps
// carries interrupt configuration, pin levels and requests
interface pafs_irq_if;
	logic [5:0] edge_sel;
	logic [2:0] int_en;
	logic [2:0] samp_en;
	logic       tick;
	logic [2:0] level;
	logic [2:0] req;

	modport ctrl (output edge_sel, output int_en, output samp_en, output tick,
		output level, input req);
	modport det (input edge_sel, input int_en, input samp_en, input tick,
		input level, output req);
endinterface

// >>> src/pafs_pin_drive.sv
`timescale 1ns/10ps
// per-pin function mux and drive type decode
module pafs_pin_drive #(
	parameter bit ALT1_OK = 1'b1,
	parameter bit ALT2_IN = 1'b0
) (
	input  wire logic                dir,
	input  wire logic [1:0]          ctl,
	input  wire pafs_pkg::pafs_func_e func,
	input  wire logic                gpio_val,
	input  wire logic                alt1_val,
	input  wire logic                alt2_val,
	input  wire logic                alt3_val,
	output logic                     drv_out,
	output logic                     drv_oe,
	output logic                     pull_up,
	output logic                     pull_down
);
	import pafs_pkg::*;

	logic val;
	logic prohibited;
	logic in_func;

	// pick the source of the pin's output value
	always_comb begin
		unique case (func)
			FUNC_GPIO: val = gpio_val; // [RULE9]
			FUNC_ALT1: val = alt1_val;
			FUNC_ALT2: val = alt2_val;
			FUNC_ALT3: val = alt3_val;
		endcase
	end

	assign prohibited = (func == FUNC_ALT1) && !ALT1_OK;
	assign in_func    = (func == FUNC_ALT2) && ALT2_IN;

	// drive type, pulls and the fixed level of a prohibited mode
	always_comb begin
		drv_out   = 1'b0;
		drv_oe    = 1'b0;
		pull_up   = 1'b0;
		pull_down = 1'b0;
		if (dir == DIR_IN) begin // [RULE5]
			pull_down = (ctl == DRV_PCH); // [RULE7] [RULE17]
			pull_up   = (ctl == DRV_NCH); // [RULE7] [RULE17]
		end else if (in_func) begin
			drv_oe = 1'b0; // pin serves as an input function
		end else if (prohibited) begin
			drv_oe = ctl[1]; // [RULE4]
		end else begin
			unique case (ctl) // [RULE6] [RULE17]
				DRV_HIZ: drv_oe = 1'b0;
				DRV_PCH: begin
					drv_out = 1'b1;
					drv_oe  = val;
				end
				DRV_NCH: drv_oe = ~val;
				DRV_CMOS: begin
					drv_out = val;
					drv_oe  = 1'b1;
				end
			endcase
		end
	end
endmodule

// >>> src/pafs_pkg.sv
// Summary of operation
// [RULE1] pin 2 mode: 00 gpio, 01 prohibited, 10 external clock in, 11 comparator 0 out
// [RULE2] pin 1 mode: 00 gpio, 01 prohibited, 10 low-speed clock, 11 timer F out
// [RULE3] pin 0 mode: 00 gpio, 01 PWM C, 10 high-speed clock, 11 timer 9 out
// [RULE4] prohibited mode in output: ignore data; hi-z or P-ch float, N-ch or CMOS low
// [RULE5] each pin is output or input by its own direction bit
// [RULE6] output drive: hi-z, P-ch open drain, N-ch open drain or CMOS by two bits
// [RULE7] input: hi-z, pull-down or pull-up by the same two control bits
// [RULE8] after reset every pin is an output with hi-z drive
// [RULE9] output mode drives each gpio pin from its data register bit
// [RULE10] reading data register returns pin level for input-mode pins
// [RULE11] one interrupt per pin, each enabled or masked on its own
// [RULE12] interrupt raised on the selected edge: rising, falling or both
// [RULE13] sampled rising mode samples pins on each 16 kHz tick falling edge
// [RULE14] sampled rising mode needs two consecutive high samples
// [RULE15] sampled request rises on the first clock after the second qualifying tick
// [RULE16] function select registers reset to zero, all pins gpio
// [RULE17] control pair: 00 hi-z, 01 P-ch or pull-down, 10 N-ch or pull-up, 11 CMOS
// [RULE18] direction bit 0 output, 1 input, resets to 0
// [RULE19] unsampled edges compare pin level between cycles, one-cycle request
package pafs_pkg;

	// register indices; byte address is four times the index
	localparam logic [15:0] IDX_DATA      = 16'hf250;
	localparam logic [15:0] IDX_DIR       = 16'hf251;
	localparam logic [15:0] IDX_DRV_LO    = 16'hf252;
	localparam logic [15:0] IDX_DRV_HI    = 16'hf253;
	localparam logic [15:0] IDX_FSEL_LO   = 16'hf254;
	localparam logic [15:0] IDX_FSEL_HI   = 16'hf255;
	localparam logic [15:0] IDX_EDGE_SEL  = 16'hf256;
	localparam logic [15:0] IDX_INT_CTRL  = 16'hf257;

	// field layout of the interrupt control register
	localparam int          INT_EN_LSB    = 0;
	localparam int          SAMP_EN_LSB   = 4;

	// values after reset and bus response codes
	localparam logic [2:0]  PORT_RST      = 3'h0;
	localparam logic [5:0]  EDGE_RST      = 6'h00;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// sampling tick timing
	localparam int          CLK_PERIOD_NS = 4;
	localparam int          TICK_PERIOD_NS = 62500;
	localparam int          TICK_CYCLES   = TICK_PERIOD_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		FUNC_GPIO = 2'b00,
		FUNC_ALT1 = 2'b01,
		FUNC_ALT2 = 2'b10,
		FUNC_ALT3 = 2'b11
	} pafs_func_e;

	typedef enum logic [1:0] {
		DRV_HIZ  = 2'b00,
		DRV_PCH  = 2'b01,
		DRV_NCH  = 2'b10,
		DRV_CMOS = 2'b11
	} pafs_drv_e;

	typedef enum logic [1:0] {
		EDGE_NONE = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_FALL = 2'b10,
		EDGE_BOTH = 2'b11
	} pafs_edge_e;

	localparam logic        DIR_OUT       = 1'b0;
	localparam logic        DIR_IN        = 1'b1;

endpackage

// >>> src/pafs_port.sv
`timescale 1ns/10ps
// three-pin port with function select, drive control and edge interrupts
module pafs_port #(
	parameter int ADDR_W      = 32,
	parameter int TICK_CYCLES = pafs_pkg::TICK_CYCLES
) (
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic [2:0]        pad_in,
	output logic [2:0]             pad_out,
	output logic [2:0]             pad_oe,
	output logic [2:0]             pad_pull_up,
	output logic [2:0]             pad_pull_down,
	input  wire logic              pwm_channel_c_output,
	input  wire logic              high_speed_clock_out,
	input  wire logic              timer_9_output,
	input  wire logic              low_speed_clock_out,
	input  wire logic              timer_f_output,
	input  wire logic              comparator0_result_out,
	output logic                   external_clock_input,
	output logic [2:0]             pin_interrupt
);
	import pafs_pkg::*;

	logic [2:0]        data_reg;
	logic [2:0]        port_direction_register;
	logic [2:0]        drive_control_low;
	logic [2:0]        drive_control_high;
	logic [2:0]        pin_function_select_low;
	logic [2:0]        pin_function_select_high;
	logic [5:0]        edge_select_control;
	logic [2:0]        int_en_reg;
	logic [2:0]        samp_en_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [7:0]        wdata_reg;
	logic              wstrb0_reg;
	logic              aw_have_reg;
	logic              w_have_reg;
	logic              do_write;
	logic [31:0]       tick_cnt_reg;
	logic              tick_reg;
	logic [2:0]        drv_out;
	logic [2:0]        drv_oe;
	logic [2:0]        drv_pu;
	logic [2:0]        drv_pd;
	logic [2:0]        alt1;
	logic [2:0]        alt2;
	logic [2:0]        alt3;

	pafs_irq_if irq ();

	// word index of a byte address, or all ones when it is not a register
	function automatic logic [15:0] reg_index(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] idx;
		idx = a >> 2;
		if ((idx >= ADDR_W'(IDX_DATA)) && (idx <= ADDR_W'(IDX_INT_CTRL)))
			return idx[15:0];
		return 16'hffff;
	endfunction

	// read value of a register; data shows the pin level for input pins
	function automatic logic [7:0] read_value(input logic [15:0] idx);
		unique case (idx)
			IDX_DATA:     return {5'h00, (port_direction_register & pad_in)
				| (~port_direction_register & data_reg)}; // [RULE10]
			IDX_DIR:      return {5'h00, port_direction_register};
			IDX_DRV_LO:   return {5'h00, drive_control_low};
			IDX_DRV_HI:   return {5'h00, drive_control_high};
			IDX_FSEL_LO:  return {5'h00, pin_function_select_low};
			IDX_FSEL_HI:  return {5'h00, pin_function_select_high};
			IDX_EDGE_SEL: return {2'h0, edge_select_control};
			IDX_INT_CTRL: return {1'b0, samp_en_reg, 1'b0, int_en_reg};
			default:      return 8'h00;
		endcase
	endfunction

	assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;

	// write channel: address and data taken in either order
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			aw_have_reg   <= 1'b0;
			w_have_reg    <= 1'b0;
			awaddr_reg    <= '0;
			wdata_reg     <= 8'h00;
			wstrb0_reg    <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_reg    <= s_axi_awaddr;
				aw_have_reg   <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_reg    <= s_axi_wdata[7:0];
				wstrb0_reg   <= s_axi_wstrb[0];
				w_have_reg   <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_have_reg  <= 1'b0;
				w_have_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (reg_index(awaddr_reg) == 16'hffff) ? RESP_SLVERR : RESP_OKAY;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// register file, written through byte lane 0
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			data_reg                 <= PORT_RST;
			port_direction_register  <= PORT_RST; // [RULE8] [RULE18]
			drive_control_low        <= PORT_RST; // [RULE8]
			drive_control_high       <= PORT_RST;
			pin_function_select_low  <= PORT_RST; // [RULE16]
			pin_function_select_high <= PORT_RST; // [RULE16]
			edge_select_control      <= EDGE_RST;
			int_en_reg               <= PORT_RST;
			samp_en_reg              <= PORT_RST;
		end else if (do_write && wstrb0_reg) begin
			unique case (reg_index(awaddr_reg))
				IDX_DATA:     data_reg <= wdata_reg[2:0];
				IDX_DIR:      port_direction_register <= wdata_reg[2:0];
				IDX_DRV_LO:   drive_control_low <= wdata_reg[2:0];
				IDX_DRV_HI:   drive_control_high <= wdata_reg[2:0];
				IDX_FSEL_LO:  pin_function_select_low <= wdata_reg[2:0];
				IDX_FSEL_HI:  pin_function_select_high <= wdata_reg[2:0];
				IDX_EDGE_SEL: edge_select_control <= wdata_reg[5:0];
				IDX_INT_CTRL: begin
					int_en_reg  <= wdata_reg[INT_EN_LSB +: 3];
					samp_en_reg <= wdata_reg[SAMP_EN_LSB +: 3];
				end
				default: ;
			endcase
		end
	end

	// read channel: one read at a time, answered on the next edge
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= {24'h000000, read_value(reg_index(s_axi_araddr))};
			s_axi_rresp   <= (reg_index(s_axi_araddr) == 16'hffff) ? RESP_SLVERR : RESP_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// sampling tick divider, one-cycle pulse per period
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_reg <= 32'h0000_0000;
			tick_reg     <= 1'b0;
		end else if (tick_cnt_reg == 32'(TICK_CYCLES - 1)) begin
			tick_cnt_reg <= 32'h0000_0000;
			tick_reg     <= 1'b1; // [RULE13]
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
			tick_reg     <= 1'b0;
		end
	end

	// alternate function sources per pin
	assign alt1 = {1'b0, 1'b0, pwm_channel_c_output}; // [RULE3]
	assign alt2 = {1'b0, low_speed_clock_out, high_speed_clock_out}; // [RULE2] [RULE3]
	assign alt3 = {comparator0_result_out, timer_f_output, timer_9_output}; // [RULE1] [RULE2]

	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_pin
			pafs_pin_drive #(
				.ALT1_OK (g == 0),
				.ALT2_IN (g == 2)
			) u_drive (
				.dir       (port_direction_register[g]),
				.ctl       ({drive_control_high[g], drive_control_low[g]}),
				.func      (pafs_func_e'({pin_function_select_high[g],
					pin_function_select_low[g]})),
				.gpio_val  (data_reg[g]),
				.alt1_val  (alt1[g]),
				.alt2_val  (alt2[g]),
				.alt3_val  (alt3[g]),
				.drv_out   (drv_out[g]),
				.drv_oe    (drv_oe[g]),
				.pull_up   (drv_pu[g]),
				.pull_down (drv_pd[g])
			);
		end
	endgenerate

	// pin outputs and external clock input from flip-flops
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pad_out              <= 3'h0;
			pad_oe               <= 3'h0; // [RULE8]
			pad_pull_up          <= 3'h0;
			pad_pull_down        <= 3'h0;
			external_clock_input <= 1'b0;
		end else begin
			pad_out              <= drv_out;
			pad_oe               <= drv_oe;
			pad_pull_up          <= drv_pu;
			pad_pull_down        <= drv_pd;
			external_clock_input <= pad_in[2] && pin_function_select_high[2]
				&& !pin_function_select_low[2]; // [RULE1]
		end
	end

	// interrupt detector
	assign irq.edge_sel = edge_select_control;
	assign irq.int_en   = int_en_reg;
	assign irq.samp_en  = samp_en_reg;
	assign irq.tick     = tick_reg;
	assign irq.level    = pad_in;

	pafs_edge_det u_edge (
		.clock (clock),
		.rst_n (rst_n),
		.irq   (irq.det)
	);

	assign pin_interrupt = irq.req;

	// checks on pin drive, external clock routing, interrupts and data reads
	property p_cmos_gpio;
		@(posedge clock) disable iff (!rst_n)
		(!port_direction_register[0] && drive_control_high[0] && drive_control_low[0]
			&& !pin_function_select_high[0] && !pin_function_select_low[0])
		|=> (pad_oe[0] && pad_out[0] == $past(data_reg[0]));
	endproperty
	a_cmos_gpio: assert property (p_cmos_gpio) else $error("gpio cmos drive wrong"); // [RULE9]

	property p_prohibited_low;
		@(posedge clock) disable iff (!rst_n)
		(!port_direction_register[1] && drive_control_high[1]
			&& !pin_function_select_high[1] && pin_function_select_low[1])
		|=> (pad_oe[1] && !pad_out[1]);
	endproperty
	a_prohibited_low: assert property (p_prohibited_low) else $error("prohibited pin not low"); // [RULE4]

	property p_input_float;
		@(posedge clock) disable iff (!rst_n)
		port_direction_register[2] |=> !pad_oe[2];
	endproperty
	a_input_float: assert property (p_input_float) else $error("input pin driven"); // [RULE5]

	property p_pull_up;
		@(posedge clock) disable iff (!rst_n)
		(port_direction_register[0] && drive_control_high[0] && !drive_control_low[0])
		|=> (pad_pull_up[0] && !pad_pull_down[0]);
	endproperty
	a_pull_up: assert property (p_pull_up) else $error("pull-up missing"); // [RULE7]

	property p_timer9;
		@(posedge clock) disable iff (!rst_n)
		(!port_direction_register[0] && drive_control_high[0] && drive_control_low[0]
			&& pin_function_select_high[0] && pin_function_select_low[0])
		|=> (pad_out[0] == $past(timer_9_output));
	endproperty
	a_timer9: assert property (p_timer9) else $error("timer 9 not routed"); // [RULE3]

	property p_ext_clk;
		@(posedge clock) disable iff (!rst_n)
		(pin_function_select_high[2] && !pin_function_select_low[2])
		|=> (external_clock_input == $past(pad_in[2]));
	endproperty
	a_ext_clk: assert property (p_ext_clk) else $error("external clock not routed"); // [RULE1]

	property p_rise_pulse;
		@(posedge clock) disable iff (!rst_n)
		($rose(pad_in[0]) && int_en_reg[0] && !samp_en_reg[0]
			&& edge_select_control[1:0] == EDGE_RISE)
		|=> pin_interrupt[0] ##1 !pin_interrupt[0];
	endproperty
	a_rise_pulse: assert property (p_rise_pulse) else $error("rising edge request wrong"); // [RULE19]

	property p_masked;
		@(posedge clock) disable iff (!rst_n)
		!int_en_reg[1] |=> !pin_interrupt[1];
	endproperty
	a_masked: assert property (p_masked) else $error("masked request raised"); // [RULE11]

	property p_sampled_after_tick;
		@(posedge clock) disable iff (!rst_n)
		(pin_interrupt[2] && samp_en_reg[2] && edge_select_control[5:4] == EDGE_RISE)
		|-> ($past(tick_reg) && $past(pad_in[2]));
	endproperty
	a_sampled_after_tick: assert property (p_sampled_after_tick) else $error("sampled early"); // [RULE15]

	property p_read_level;
		@(posedge clock) disable iff (!rst_n)
		(s_axi_arvalid && s_axi_arready && reg_index(s_axi_araddr) == IDX_DATA
			&& port_direction_register == 3'h7)
		|=> (s_axi_rvalid && s_axi_rdata[2:0] == $past(pad_in));
	endproperty
	a_read_level: assert property (p_read_level) else $error("data read not pin level"); // [RULE10]

	c_write: cover property (@(posedge clock) disable iff (!rst_n) do_write);
	c_read: cover property (@(posedge clock) disable iff (!rst_n) s_axi_rvalid && s_axi_rready);
	c_irq: cover property (@(posedge clock) disable iff (!rst_n) |pin_interrupt);
	c_samp: cover property (@(posedge clock) disable iff (!rst_n)
		pin_interrupt[0] && samp_en_reg[0]);
endmodule

// >>> testbench/pafs_pin_model.sv
`timescale 1ns/10ps
// far side of the port: pads with external drivers, pulls and floating lines
module pafs_pin_model (
	input  wire logic       clock,
	input  wire logic [2:0] pad_out,
	input  wire logic [2:0] pad_oe,
	input  wire logic [2:0] pad_pull_up,
	input  wire logic [2:0] pad_pull_down,
	input  wire logic [2:0] ext_val,
	input  wire logic [2:0] ext_en,
	output logic      [2:0] pad_in
);
	logic [2:0] float_pat = 3'h5;

	// an undriven, unpulled line wanders so that no stale level is mistaken for a drive
	always @(posedge clock) begin
		float_pat <= ~float_pat;
	end

	// resolve each pad: device drive wins, then the external driver, then the pulls
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			if (pad_oe[i]) begin
				pad_in[i] = pad_out[i];
			end else if (ext_en[i]) begin
				pad_in[i] = ext_val[i];
			end else if (pad_pull_up[i]) begin
				pad_in[i] = 1'b1;
			end else if (pad_pull_down[i]) begin
				pad_in[i] = 1'b0;
			end else begin
				pad_in[i] = float_pat[i];
			end
		end
	end
endmodule

// >>> testbench/port_a_function_select_gpio_tb.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin errors++; $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp); end end
module port_a_function_select_gpio_tb;
	import pafs_pkg::*;
	localparam int TICKS = 8;
	logic        clock = 1'b0, rst_n = 1'b0;
	logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
	logic [3:0]  wstrb = '0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, ext_clk;
	logic [1:0]  bresp, rresp;
	logic [5:0]  src = '0;
	logic [2:0]  pad_in, pad_out, pad_oe, pad_pu, pad_pd, pin_irq;
	logic [2:0]  ext_val = '0, ext_en = '0, d, eo, ex, en, seen;
	logic [1:0]  bq[$], exp_b;
	logic [33:0] rq[$], exp_r;
	logic [7:0]  hi;
	int          errors = 0, check_count = 0, cyc = 0, c, m, e;

	pafs_port #(.TICK_CYCLES(TICKS)) DUT (.clock(clock), .rst_n(rst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pull_up(pad_pu),
		.pad_pull_down(pad_pd), .pwm_channel_c_output(src[0]), .high_speed_clock_out(src[1]),
		.timer_9_output(src[2]), .low_speed_clock_out(src[3]), .timer_f_output(src[4]),
		.comparator0_result_out(src[5]), .external_clock_input(ext_clk),
		.pin_interrupt(pin_irq));

	pafs_pin_model pins (.clock(clock), .pad_out(pad_out), .pad_oe(pad_oe),
		.pad_pull_up(pad_pu), .pad_pull_down(pad_pd), .ext_val(ext_val), .ext_en(ext_en),
		.pad_in(pad_in));

	// clock and hang guard
	always #2 clock = ~clock;
	always @(posedge clock) begin
		cyc++;
		if (cyc == 8000) begin
			errors++;
			stop_test();
		end
	end

	// bus answers are matched against the oldest noted expectation
	always @(posedge clock) begin
		if (bvalid && bready) begin
			exp_b = bq.pop_front();
			`CHK(bresp, exp_b)
		end
		if (rvalid && rready) begin
			exp_r = rq.pop_front();
			`CHK({rresp, rdata}, exp_r)
		end
	end

	task automatic stop_test();
		$display("errors=%0d checks=%0d", errors, check_count);
		if (errors == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// one register write, address and data offered together
	task automatic wr(input logic [15:0] idx, input logic [7:0] v, input logic [1:0] er = RESP_OKAY);
		@(posedge clock);
		awaddr <= {14'h0, idx, 2'b00};
		wdata <= {24'h0, v};
		wstrb <= 4'h1;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		bq.push_back(er);
		do begin
			@(posedge clock);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!(bvalid && bready));
		bready <= 1'b0;
	endtask

	// one register read; the expected word is noted for the monitor
	task automatic rd(input logic [15:0] idx, input logic [7:0] v, input logic [1:0] er = RESP_OKAY);
		@(posedge clock);
		araddr <= {14'h0, idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		rq.push_back({er, 24'h0, v});
		do begin
			@(posedge clock);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!(rvalid && rready));
		rready <= 1'b0;
	endtask

	// gather interrupt pulses over a number of cycles
	task automatic watch(input int n);
		seen = 3'h0;
		hi = 8'h00;
		repeat (n) begin
			@(posedge clock);
			seen |= pin_irq;
			hi += 8'(|pin_irq);
		end
	endtask

	task automatic drv(input int code);
		wr(IDX_DRV_LO, {5'h0, {3{code[0]}}});
		wr(IDX_DRV_HI, {5'h0, {3{code[1]}}});
		repeat (3) @(posedge clock);
	endtask

	initial begin
		void'($urandom(32'h9258eab7));
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		`CHK(pad_oe, PORT_RST)
		// reset values, then an unmapped place
		for (int i = 0; i < 8; i++) rd(IDX_DATA + 16'(i), 8'h00);
		rd(16'hf258, 8'h00, RESP_SLVERR);
		wr(16'hf258, 8'hff, RESP_SLVERR);
		// each output drive code with random data
		for (c = 0; c < 4; c++) begin
			d = 3'($urandom);
			wr(IDX_DATA, {5'h0, d});
			drv(c);
			eo = (c == 0) ? 3'h0 : (c == 1) ? d : (c == 2) ? ~d : 3'h7;
			`CHK(pad_oe, eo)
			`CHK(pad_out & eo, d & eo)
			rd(IDX_DATA, {5'h0, d});
			rd(IDX_DRV_HI, {5'h0, {3{c[1]}}});
		end
		// alternate functions under cmos drive
		wr(IDX_DATA, 8'h00);
		ext_en <= 3'h4;
		for (m = 1; m < 4; m++) begin
			src <= 6'($urandom);
			ext_val <= 3'($urandom);
			wr(IDX_FSEL_LO, {5'h0, {3{m[0]}}});
			wr(IDX_FSEL_HI, {5'h0, {3{m[1]}}});
			repeat (3) @(posedge clock);
			eo = {1'(m != 2), 2'b11};
			ex = {(m == 3) & src[5], (m != 1) & src[m + 1], src[m - 1]};
			`CHK(pad_oe, eo)
			`CHK(pad_out & eo, ex & eo)
			if (m == 2) `CHK(ext_clk, ext_val[2])
			else `CHK(ext_clk, 1'b0)
		end
		// prohibited code on pins 1 and 2 ignores the data register
		wr(IDX_FSEL_LO, 8'h06);
		wr(IDX_FSEL_HI, 8'h00);
		wr(IDX_DATA, 8'h07);
		for (c = 0; c < 4; c++) begin
			drv(c);
			`CHK(pad_oe[2:1], {2{c[1]}})
			`CHK(pad_out[2:1] & {2{c[1]}}, 2'b00)
		end
		// mixed direction: pins 0 and 2 input with pulls, pin 1 output
		wr(IDX_FSEL_LO, 8'h00);
		ext_en <= 3'h5;
		wr(IDX_DIR, 8'h05);
		for (c = 0; c < 4; c++) begin
			ext_val <= 3'($urandom);
			drv(c);
			`CHK(pad_pu, (c == 2) ? 3'h5 : 3'h0)
			`CHK(pad_pd, (c == 1) ? 3'h5 : 3'h0)
			`CHK(pad_oe & 3'h5, 3'h0)
			rd(IDX_DATA, {5'h0, (ext_val & 3'h5) | 3'h2});
		end
		// unsampled edge interrupts with masking
		ext_en <= 3'h7;
		ext_val <= 3'h0;
		wr(IDX_DIR, 8'h07);
		rd(IDX_DATA, 8'h00);
		for (e = 1; e < 4; e++) begin
			en = (e == 3) ? 3'h5 : 3'h7;
			wr(IDX_EDGE_SEL, {2'b00, {3{e[1:0]}}});
			wr(IDX_INT_CTRL, {5'h0, en});
			repeat (3) @(posedge clock);
			ext_val <= 3'h7;
			watch(6);
			`CHK(seen, e[0] ? en : 3'h0)
			`CHK(hi, int'(e[0]))
			ext_val <= 3'h0;
			watch(6);
			`CHK(seen, e[1] ? en : 3'h0)
		end
		// sampled rising: a short glitch is filtered, a held level fires once
		wr(IDX_EDGE_SEL, 8'h15);
		rd(IDX_EDGE_SEL, 8'h15);
		wr(IDX_INT_CTRL, 8'h77);
		repeat (3 * TICKS) @(posedge clock);
		ext_val <= 3'h7;
		repeat (3) @(posedge clock);
		ext_val <= 3'h0;
		watch(3 * TICKS);
		`CHK(seen, 3'h0)
		ext_val <= 3'h7;
		watch(TICKS);
		`CHK(seen, 3'h0)
		watch(2 * TICKS + 4);
		`CHK(seen, 3'h7)
		`CHK(hi, 1)
		stop_test();
	end
endmodule
